// *** rtl/aicd_coder.sv ***
// Output coder: straight binary or twos complement.
// Assumes raw offset-binary results from the converter core.
`timescale 1ns/10ps
module aicd_coder #(
    parameter int DW = 16
) (
    input  wire logic [DW-1:0] rawCode,
    input  wire logic          bipolar,
    output logic [DW-1:0]      codedOut
);
    always_comb begin
        codedOut = rawCode;
        if (bipolar) begin
            codedOut[DW-1] = ~rawCode[DW-1];
        end
    end
endmodule // aicd_coder

// *** rtl/aicd_mux_decode.sv ***
// Decoder from configuration fields to multiplexer controls.
// Assumes a registered configuration word and sequencer channel at the input.
`timescale 1ns/10ps
module aicd_mux_decode #(
    parameter int CHW = 3
) (
    input  wire logic [2:0]     incc,
    input  wire logic [CHW-1:0] chSel,
    input  wire logic           seqActive,
    input  wire logic [CHW-1:0] seqChan,
    output logic [CHW-1:0]      posChan,
    output logic [CHW-1:0]      negChan,
    output logic                negIsCom,
    output logic                negIsGnd,
    output logic                bipolar,
    output logic                paired
);
    aicd_pkg::aicd_mode_t mode;
    logic [CHW-1:0]       rawChan;

    always_comb begin
        mode     = aicd_pkg::decodeMode(incc);
        paired   = (mode == aicd_pkg::AICD_PAIR_BIP) || (mode == aicd_pkg::AICD_PAIR_GND);
        rawChan  = seqActive ? seqChan : chSel;
        posChan  = rawChan;
        if (paired && seqActive) begin
            posChan = {rawChan[CHW-1:1], 1'b0};
        end
        negChan  = {posChan[CHW-1:1], ~posChan[0]};
        negIsCom = (mode == aicd_pkg::AICD_COM_BIP) || (mode == aicd_pkg::AICD_COM_GND);
        negIsGnd = (mode == aicd_pkg::AICD_SINGLE);
        bipolar  = (mode == aicd_pkg::AICD_COM_BIP) || (mode == aicd_pkg::AICD_PAIR_BIP);
    end
endmodule // aicd_mux_decode

// *** rtl/aicd_pkg.sv ***
// Package of constants for the input configuration decoder.
// Assumes a 14-bit configuration word and an 8-channel multiplexer.
package aicd_pkg;
    // ****************************
    // Word layout
    // ****************************
    localparam int CFG_WIDTH   = 14;
    localparam int INCC_HI     = 12;
    localparam int INCC_LO     = 10;
    localparam int CHSEL_HI    = 9;
    localparam int CHSEL_LO    = 7;
    localparam int BW_BIT      = 6;
    localparam int CH_WIDTH    = 3;
    localparam int NUM_CH      = 8;
    localparam int DATA_WIDTH  = 16;
    // ****************************
    // Input configuration codes
    // ****************************
    localparam logic [2:0] INCC_SINGLE    = 3'h7;
    localparam logic [2:0] INCC_COM_BIP   = 3'h2;
    localparam logic [2:0] INCC_COM_GND   = 3'h6;
    localparam logic [1:0] INCC_PAIR_BIP  = 2'h0;
    localparam logic [1:0] INCC_PAIR_GND  = 2'h2;
    // ****************************
    // Register map
    // ****************************
    localparam logic [11:0] ADDR_CFG    = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RESULT = 12'h008;
    localparam logic [13:0] CFG_RESET   = 14'h3FFF;
    // ****************************
    // Types
    // ****************************
    typedef enum logic [2:0] {
        AICD_SINGLE,
        AICD_COM_BIP,
        AICD_COM_GND,
        AICD_PAIR_BIP,
        AICD_PAIR_GND,
        AICD_INVALID
    } aicd_mode_t;
    // Mode decoding used by the multiplexer decoder
    function automatic aicd_mode_t decodeMode(input logic [2:0] incc);
        if (incc == INCC_SINGLE)               return AICD_SINGLE;
        else if (incc == INCC_COM_BIP)         return AICD_COM_BIP;
        else if (incc == INCC_COM_GND)         return AICD_COM_GND;
        else if (incc[2:1] == INCC_PAIR_BIP)   return AICD_PAIR_BIP;
        else if (incc[2:1] == INCC_PAIR_GND)   return AICD_PAIR_GND;
        else                                   return AICD_INVALID;
    endfunction
endpackage

// *** rtl/aicd_top.sv ***
// Input configuration decoder with APB register access.
// Assumes an APB master on mclk and a converter core supplying raw codes.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Field 111 gives single-ended inputs against ground, unipolar.
// - Field 010 gives inputs against the common input at half reference, bipolar.
// - Field 110 gives inputs against the common input as ground sense, unipolar.
// - Field 00x gives adjacent pairs with negative at half reference, bipolar.
// - Field 10x gives adjacent pairs with negative as ground sense, unipolar.
// - In paired modes an even channel value puts the positive input on an even channel.
// - In paired modes an odd channel value puts the positive input on an odd channel.
// - The sequencer in paired modes always uses even channels as positive inputs.
// - One bit selects full or quarter bandwidth for the input filter.
// - Bipolar configurations give twos complement results.
// - Unipolar configurations give straight binary results.
// - The fields live in a 14-bit configuration word written by the host.
module aicd_top #(
    parameter int CFGW = aicd_pkg::CFG_WIDTH,
    parameter int CHW  = aicd_pkg::CH_WIDTH,
    parameter int DW   = aicd_pkg::DATA_WIDTH
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire logic          seqActive,
    input  wire logic [CHW-1:0] seqChan,
    input  wire logic          rawValid,
    input  wire logic [DW-1:0] rawCode,
    output logic [CHW-1:0]     positivePairInput,
    output logic [CHW-1:0]     negativePairInput,
    output logic               negIsCom,
    output logic               negIsGnd,
    output logic               bipolarRange,
    output logic               pairedMode,
    output logic               quarterBw,
    output logic [DW-1:0]      resultOut
);
    // ****************************
    // State
    // ****************************
    logic [CFGW-1:0] cfg_ff, nxt_cfg;
    logic [DW-1:0]   result_ff, nxt_result;
    logic [31:0]     prdata_ff, nxt_prdata;
    logic            pready_ff, nxt_pready;
    logic            pslverr_ff, nxt_pslverr;
    logic [CHW-1:0]  pos_ff, neg_ff, nxt_pos, nxt_neg;
    logic            com_ff, gnd_ff, bip_ff, pair_ff, qbw_ff;
    logic            nxtCom, nxtGnd, nxtBip, nxtPair;
    logic [CHW-1:0]  decPos, decNeg;
    logic [DW-1:0]   coded;
    logic            access;

    // ****************************
    // Decode
    // ****************************
    aicd_mux_decode #(.CHW(CHW)) uDec (
        .incc      (cfg_ff[aicd_pkg::INCC_HI:aicd_pkg::INCC_LO]),
        .chSel     (cfg_ff[aicd_pkg::CHSEL_HI:aicd_pkg::CHSEL_LO]),
        .seqActive (seqActive),
        .seqChan   (seqChan),
        .posChan   (decPos),
        .negChan   (decNeg),
        .negIsCom  (nxtCom),
        .negIsGnd  (nxtGnd),
        .bipolar   (nxtBip),
        .paired    (nxtPair)
    );

    aicd_coder #(.DW(DW)) uCode (
        .rawCode  (rawCode),
        .bipolar  (bip_ff),
        .codedOut (coded)
    );

    // ****************************
    // Registers
    // ****************************
    always_comb begin
        access      = psel && penable && !pready_ff;
        nxt_cfg     = cfg_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = access;
        nxt_pslverr = 1'b0;
        nxt_result  = rawValid ? coded : result_ff;
        nxt_pos     = decPos;
        nxt_neg     = nxtPair ? decNeg : decPos;
        if (access) begin
            nxt_prdata = 32'h0000_0000;
            if (paddr == aicd_pkg::ADDR_CFG) begin
                if (pwrite) begin
                    nxt_cfg = pwdata[CFGW-1:0];
                end else begin
                    nxt_prdata[CFGW-1:0] = cfg_ff;
                end
            end else if (paddr == aicd_pkg::ADDR_STATUS) begin
                if (!pwrite) begin
                    nxt_prdata[7:0] = {pair_ff, bip_ff, qbw_ff, gnd_ff, com_ff, pos_ff};
                end
            end else if (paddr == aicd_pkg::ADDR_RESULT) begin
                if (!pwrite) begin
                    nxt_prdata[DW-1:0] = result_ff;
                end
            end else begin
                nxt_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_ff     <= aicd_pkg::CFG_RESET;
            result_ff  <= '0;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            pos_ff     <= '0;
            neg_ff     <= '0;
            com_ff     <= 1'b0;
            gnd_ff     <= 1'b1;
            bip_ff     <= 1'b0;
            pair_ff    <= 1'b0;
            qbw_ff     <= 1'b0;
        end else begin
            cfg_ff     <= nxt_cfg;
            result_ff  <= nxt_result;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            pos_ff     <= nxt_pos;
            neg_ff     <= nxt_neg;
            com_ff     <= nxtCom;
            gnd_ff     <= nxtGnd;
            bip_ff     <= nxtBip;
            pair_ff    <= nxtPair;
            qbw_ff     <= cfg_ff[aicd_pkg::BW_BIT];
        end
    end

    assign pready            = pready_ff;
    assign prdata            = prdata_ff;
    assign pslverr           = pslverr_ff;
    assign positivePairInput = pos_ff;
    assign negativePairInput = neg_ff;
    assign negIsCom          = com_ff;
    assign negIsGnd          = gnd_ff;
    assign bipolarRange      = bip_ff;
    assign pairedMode        = pair_ff;
    assign quarterBw         = qbw_ff;
    assign resultOut         = result_ff;

    // ****************************
    // Checks
    // ****************************
    single_mode_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cfg_ff[12:10]) == 3'h7 && !$past(sys_rst) |-> negIsGnd && !bipolarRange)
        else $error("single-ended decode wrong");
    com_bip_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cfg_ff[12:10]) == 3'h2 && !$past(sys_rst) |-> negIsCom && bipolarRange)
        else $error("common bipolar decode wrong");
    com_gnd_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cfg_ff[12:10]) == 3'h6 && !$past(sys_rst) |-> negIsCom && !bipolarRange)
        else $error("common ground decode wrong");
    pair_bip_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cfg_ff[12:11]) == 2'h0 && !$past(sys_rst) |-> pairedMode && bipolarRange)
        else $error("bipolar pair decode wrong");
    pair_gnd_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(cfg_ff[12:11]) == 2'h2 && !$past(sys_rst) |-> pairedMode && !bipolarRange)
        else $error("ground pair decode wrong");
    chan_parity_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !$past(seqActive) && !$past(sys_rst) |-> positivePairInput == $past(cfg_ff[9:7]))
        else $error("positive channel wrong");
    seq_even_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(seqActive) && pairedMode && !$past(sys_rst) |-> !positivePairInput[0])
        else $error("sequencer used odd channel");
    bw_select_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !$past(sys_rst) |-> quarterBw == $past(cfg_ff[6]))
        else $error("bandwidth bit not followed");
    twos_comp_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(rawValid) && !$past(sys_rst) |->
        resultOut[DW-1] == ($past(rawCode[DW-1]) ^ $past(bip_ff)))
        else $error("output coding wrong");
    partner_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pairedMode |->
        negativePairInput == {positivePairInput[CHW-1:1], ~positivePairInput[0]})
        else $error("pair partner wrong");
    cfg_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
        psel && penable && pwrite && !pready && paddr == aicd_pkg::ADDR_CFG |=>
        cfg_ff == $past(pwdata[CFGW-1:0]))
        else $error("config write lost");
endmodule // aicd_top

// *** tb/adc_input_config_decoder_tb.sv ***
// Testbench for the input configuration decoder.
// Assumes the host model drives APB and the bench drives the core side.
`timescale 1ns/10ps
module adc_input_config_decoder_tb;
    typedef struct {
        logic [13:0] cfg;
        logic [15:0] raw;
        logic [2:0]  pos;
        logic [4:0]  flg;
        logic [15:0] res;
    } aicd_row_t;
    logic        mclk, sysRst, psel, penable, pwrite, pready, pslverr, err;
    logic        seqActive, rawValid, negIsCom, negIsGnd, bipolarRange, pairedMode, quarterBw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  seqChan, positivePairInput, negativePairInput;
    logic [15:0] rawCode, resultOut;
    int          nMismatch, compares, cyc;
    aicd_row_t   rows[8];
    aicd_host_model host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    aicd_top uut (.mclk(mclk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .seqActive(seqActive), .seqChan(seqChan), .rawValid(rawValid),
        .rawCode(rawCode), .positivePairInput(positivePairInput),
        .negativePairInput(negativePairInput), .negIsCom(negIsCom), .negIsGnd(negIsGnd),
        .bipolarRange(bipolarRange), .pairedMode(pairedMode), .quarterBw(quarterBw),
        .resultOut(resultOut));
    // ********
    // Helpers
    // ********
    function automatic logic [13:0] mk(input logic [2:0] m, input logic [2:0] c, input logic b);
        return {1'h0, m, c, b, 6'h00};
    endfunction
    task automatic print_verdict;
        $display("mismatches %0d compares %0d", nMismatch, compares);
        if (nMismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Flags are {com, gnd, bipolar, paired, quarter}
    task automatic chkDec(input logic [2:0] p, input logic [2:0] n, input logic [4:0] f);
        chk("positive", 16'(p), 16'(positivePairInput));
        chk("negative", 16'(n), 16'(negativePairInput));
        chk("flags", 16'(f), 16'({negIsCom, negIsGnd, bipolarRange, pairedMode, quarterBw}));
    endtask
    task automatic pulse(input logic [15:0] r);
        @(posedge mclk);
        rawValid <= 1'h1;
        rawCode  <= r;
        @(posedge mclk);
        rawValid <= 1'h0;
        @(posedge mclk);
    endtask
    // ********
    // Clock and timeout
    // ********
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            nMismatch++;
            print_verdict();
        end
    end
    // ********
    // Main sequence
    // ********
    initial begin
        sysRst = 1'h1;
        seqActive = 1'h0;
        seqChan = 3'h0;
        rawValid = 1'h0;
        rawCode = 16'h0000;
        rows = '{'{mk(3'h7, 3'h3, 1'h0), 16'h8001, 3'h3, 5'h08, 16'h8001},
                 '{mk(3'h2, 3'h2, 1'h1), 16'h8001, 3'h2, 5'h15, 16'h0001},
                 '{mk(3'h6, 3'h5, 1'h0), 16'h0000, 3'h5, 5'h10, 16'h0000},
                 '{mk(3'h0, 3'h0, 1'h0), 16'h7FFF, 3'h0, 5'h06, 16'hFFFF},
                 '{mk(3'h1, 3'h5, 1'h0), 16'h0000, 3'h5, 5'h06, 16'h8000},
                 '{mk(3'h4, 3'h6, 1'h1), 16'hFFFF, 3'h6, 5'h03, 16'hFFFF},
                 '{mk(3'h5, 3'h7, 1'h0), 16'h1234, 3'h7, 5'h02, 16'h1234},
                 '{mk(3'h3, 3'h1, 1'h0), 16'h8001, 3'h1, 5'h00, 16'h8001}};
        repeat (5) @(posedge mclk);
        chkDec(3'h0, 3'h0, 5'h08);
        chk("result", 16'h0000, resultOut);
        sysRst <= 1'h0;
        host.xfer(1'h0, aicd_pkg::ADDR_CFG, 32'h0, rd, err);
        chk("cfg", 16'h3FFF, rd[15:0]);
        foreach (rows[i]) begin
            host.writeCfg(rows[i].cfg);
            repeat (2) @(posedge mclk);
            chkDec(rows[i].pos, rows[i].flg[1] ? rows[i].pos ^ 3'h1 : rows[i].pos, rows[i].flg);
            pulse(rows[i].raw);
            chk("result", rows[i].res, resultOut);
            repeat (rows[i].flg[0] ? 8 : 2) @(posedge mclk);
        end
        // Sequencer in paired mode turns odd choices into the even channel below
        host.writeCfg(mk(3'h1, 3'h5, 1'h0));
        @(posedge mclk);
        seqActive <= 1'h1;
        seqChan   <= 3'h3;
        repeat (2) @(posedge mclk);
        chkDec(3'h2, 3'h3, 5'h06);
        seqChan <= 3'h5;
        repeat (2) @(posedge mclk);
        chkDec(3'h4, 3'h5, 5'h06);
        seqActive <= 1'h0;
        repeat (2) @(posedge mclk);
        host.xfer(1'h0, aicd_pkg::ADDR_STATUS, 32'h0, rd, err);
        chk("status", 16'h00C5, rd[15:0]);
        host.xfer(1'h1, aicd_pkg::ADDR_STATUS, 32'hFFFFFFFF, rd, err);
        chk("error", 16'h0000, 16'(err));
        host.xfer(1'h0, aicd_pkg::ADDR_STATUS, 32'h0, rd, err);
        chk("status", 16'h00C5, rd[15:0]);
        host.xfer(1'h1, 12'h00C, 32'h00000000, rd, err);
        chk("error", 16'h0001, 16'(err));
        host.xfer(1'h0, aicd_pkg::ADDR_CFG, 32'h0, rd, err);
        chk("cfg", 16'(mk(3'h1, 3'h5, 1'h0)), rd[15:0]);
        // Second reset in mid-run
        @(posedge mclk);
        sysRst <= 1'h1;
        repeat (2) @(posedge mclk);
        chkDec(3'h0, 3'h0, 5'h08);
        chk("result", 16'h0000, resultOut);
        sysRst <= 1'h0;
        host.xfer(1'h0, aicd_pkg::ADDR_CFG, 32'h0, rd, err);
        chk("cfg", 16'h3FFF, rd[15:0]);
        chkDec(3'h7, 3'h7, 5'h09);
        print_verdict();
    end
endmodule // adc_input_config_decoder_tb

// *** tb/aicd_host_model.sv ***
// Host model: APB master that writes and reads the configuration word.
// Assumes the bench calls its tasks and that mclk runs freely.
`timescale 1ns/10ps
module aicd_host_model (
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // ********
    // Bus idle at start
    // ********
    initial begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end
    // ********
    // One transfer, held until pready
    // ********
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel   <= 1'h1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask
    // Whole 14-bit word in one write
    task automatic writeCfg(input logic [13:0] c);
        logic [31:0] rd;
        logic        err;
        xfer(1'h1, aicd_pkg::ADDR_CFG, {18'h00000, c}, rd, err);
    endtask
endmodule // aicd_host_model
